// File: bench/iom_pin_model.sv
module iom_pin_model
    import iom_pkg::*;
#(
    parameter int NPORTS = 5
)
(
    input  wire iom_drv_t [NPORTS*8-1:0] pin_drv,
    input  wire logic [NPORTS*8-1:0]     ext_low,
    output logic [NPORTS*8-1:0]          pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Pad resolution
    // ------------------------------------------------------------
    // board pull-up
    // Every pad has a resistor to supply, so a released line reads 1
    always_comb
    begin
        for (int i = 0; i < NPORTS*8; i++)
            pin_in[i] = !(pin_drv[i].pull_down || ext_low[i]);
    end
endmodule

// File: bench/iom_port_ctrl_asserts.sv
module iom_port_ctrl_asserts
    import iom_pkg::*;
#(
    parameter int NPORTS = 5
)
(
    input wire logic                    clk,
    input wire logic                    arst_n,
    input wire iom_bus_req_t            bus_req,
    input wire logic [7:0]              bus_rdata,
    input wire logic [NPORTS*8-1:0]     port_latch,
    input wire logic                    strap_reset_level_high_sel,
    input wire logic                    timer0_ovf,
    input wire iom_drv_t [NPORTS*8-1:0] pin_drv,
    input wire logic [NPORTS*8-1:0]     pin_level,
    input wire logic                    port_reset_level,
    input wire logic                    ext_reset_req,
    input wire logic                    timer0_toggle_out,
    input wire logic                    osc_output_pin_o,
    input wire logic                    osc_output_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // Bus, straps and special pins
    // ------------------------------------------------------------
    // Guard with the previous edge: outputs are still zero on the first edge out of reset
    rd_idle_zero_a:
        assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside its slot");
    ded_pin_input_a:
        assert property ($past(arst_n) |-> pin_drv[12] == 5'h01)
        else $error("dedicated pin drives or lacks schmitt");
    ser_pin_od_a:
        assert property ($past(arst_n) |-> pin_drv[13][4:2] == 3'h0 && pin_drv[14][4:2] == 3'h0
                         && pin_drv[14].pull_down == !$past(port_latch[14]))
        else $error("serial pin not open drain");
    rst_level_cap_a:
        assert property ($past(arst_n) && !$past(arst_n, 2)
                         |-> port_reset_level == $past(strap_reset_level_high_sel))
        else $error("reset level strap not captured");
    ext_rst_pin_a:
        assert property (ext_reset_req |-> pin_level[12] == 1'h0)
        else $error("reset request with pin level high");
    t0_toggle_cause_a:
        assert property (timer0_toggle_out != $past(timer0_toggle_out) |-> $past(timer0_ovf))
        else $error("toggle output moved without overflow");

    // ------------------------------------------------------------
    // Clock output
    // ------------------------------------------------------------
    sequence clk_out_running;
        osc_output_pin_oe [*4];
    endsequence
    clkout_period_a:
        assert property (clk_out_running |-> osc_output_pin_o != $past(osc_output_pin_o, 2))
        else $error("clock output period not four");
    clkout_off_low_a:
        assert property (!osc_output_pin_oe |-> !osc_output_pin_o)
        else $error("clock output high while disabled");

    // ------------------------------------------------------------
    // Per pin driver enables
    // ------------------------------------------------------------
    for (genvar i = 0; i < NPORTS*8; i++)
    begin : g_pin
        strong_needs_one_a:
            assert property (pin_drv[i].strong_pu |-> $past(port_latch[i]))
            else $error("strong pull-up with latch low");
        pull_down_zero_a:
            assert property (pin_drv[i].pull_down |-> !$past(port_latch[i]))
            else $error("pull-down with latch high");
        weak_with_vweak_a:
            assert property (pin_drv[i].weak_pu |-> pin_drv[i].very_weak_pu)
            else $error("weak pull-up without very weak");
    end
endmodule

bind iom_port_ctrl iom_port_ctrl_asserts #(.NPORTS(NPORTS)) u_chk (
    .clk, .arst_n, .bus_req, .bus_rdata, .port_latch, .strap_reset_level_high_sel,
    .timer0_ovf, .pin_drv, .pin_level, .port_reset_level, .ext_reset_req,
    .timer0_toggle_out, .osc_output_pin_o, .osc_output_pin_oe
);

// File: bench/test_iom_port_ctrl.sv
`include "iom_regs.svh"

module test_iom_port_ctrl
    import iom_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic            clk;
    logic            arst_n;
    iom_bus_req_t    bus_req;
    logic [7:0]      bus_rdata;
    logic [39:0]     port_latch;
    logic [39:0]     pin_in;
    logic [39:0]     pin_level;
    logic [39:0]     ext_low;
    iom_drv_t [39:0] pin_drv;
    logic            strap_reset_level_high_sel;
    logic            strap_reset_pin_disable;
    logic            osc_src_rc_or_ext;
    logic            timer0_ovf;
    logic            timer1_ovf;
    logic            port_reset_level;
    logic            ext_reset_req;
    logic            timer0_toggle_out;
    logic            timer1_toggle_out;
    logic            osc_output_pin_o;
    logic            osc_output_pin_oe;
    logic            last;
    int              err_count;
    int              checks_done;
    int              n;
    logic [7:0]      ofs [13] = '{8'h9e, 8'h9f, 8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb5, 8'hb6,
                                  8'hec, 8'ha6, 8'hfa, 8'hfb, 8'h00};
    logic [7:0]      msk [13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h8f, 8'h8f, 8'hff, 8'hff,
                                  8'h1f, 8'h0d, 8'h0f, 8'h0f, 8'h00};

    iom_port_ctrl #(.NPORTS(5)) dut (
        .clk, .arst_n, .bus_req, .bus_rdata, .port_latch, .pin_in,
        .strap_reset_level_high_sel, .strap_reset_pin_disable, .osc_src_rc_or_ext,
        .timer0_ovf, .timer1_ovf, .pin_drv, .pin_level, .port_reset_level, .ext_reset_req,
        .timer0_toggle_out, .timer1_toggle_out, .osc_output_pin_o, .osc_output_pin_oe
    );
    iom_pin_model #(.NPORTS(5)) far_side (.pin_drv, .ext_low, .pin_in);

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic drv_chk(input int p, input logic [4:0] exp);
        chk({3'h0, pin_drv[p]}, {3'h0, exp});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'h1, 1'h0};
        @(posedge clk);
        bus_req.wr <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{a, 8'h00, 1'h0, 1'h1};
        @(posedge clk);
        bus_req.rd <= 1'h0;
        #1;
        chk(bus_rdata, exp);
    endtask
    task automatic do_reset();
        arst_n <= 1'h0;
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
    endtask
    task automatic conclude();
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Expected enables {very weak, weak, strong, pull-down, schmitt} per mode
    function automatic logic [4:0] exp_drv(input logic [1:0] m, input logic l);
        case (m)
            2'h0: return {l, l, 1'h0, !l, 1'h0};
            2'h1: return {2'h0, l, !l, 1'h0};
            2'h2: return 5'h00;
            default: return {3'h0, !l, 1'h0};
        endcase
    endfunction

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #100000;
        err_count++;
        conclude();
    end
    initial
    begin
        arst_n = 1'h0;
        bus_req = '0;
        port_latch = '0;
        ext_low = '0;
        {strap_reset_level_high_sel, strap_reset_pin_disable, osc_src_rc_or_ext} = 3'h1;
        {timer0_ovf, timer1_ovf} = 2'h0;
        err_count = 0;
        checks_done = 0;
        do_reset();
        foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
        foreach (ofs[i]) wr(ofs[i], 8'hff);
        foreach (ofs[i]) rd_chk(ofs[i], msk[i]);
        drv_chk(12, 5'h01);
        drv_chk(0, 5'h03);
        foreach (ofs[i]) wr(ofs[i], 8'h00);
        $display("test registers done");
        for (int m = 0; m < 4; m++)
            for (int l = 0; l < 2; l++)
            begin
                @(posedge clk);
                port_latch[1:0] <= {2{l[0]}};
                wr(`IOM_P0_MODE_A_OFS, {6'h00, m[1], 1'h0});
                wr(`IOM_P0_MODE_B_OFS, {6'h00, m[0], 1'h0});
                tick(5);
                drv_chk(1, exp_drv(m[1:0], l[0]));
                drv_chk(0, exp_drv(2'h0, l[0]));
            end
        wr(`IOM_P0_MODE_A_OFS, 8'h00);
        wr(`IOM_P0_MODE_B_OFS, 8'h00);
        #1;
        drv_chk(1, 5'h04);
        tick(1);
        drv_chk(1, 5'h18);
        @(posedge clk);
        port_latch[1] <= 1'h0;
        tick(4);
        @(posedge clk);
        port_latch[1] <= 1'h1;
        for (int k = 0; k < 3; k++)
        begin
            tick(1);
            chk({7'h00, pin_drv[1].strong_pu}, {7'h00, k < 2});
        end
        @(posedge clk);
        ext_low[1] <= 1'h1;
        tick(5);
        drv_chk(1, 5'h10);
        @(posedge clk);
        ext_low[1] <= 1'h0;
        wr(`IOM_THRESH_OFS, 8'h02);
        port_latch[13] <= 1'h1;
        tick(5);
        drv_chk(1, 5'h18);
        drv_chk(8, 5'h03);
        drv_chk(12, 5'h01);
        drv_chk(13, 5'h01);
        drv_chk(14, 5'h03);
        $display("test pin modes done");
        @(posedge clk);
        osc_src_rc_or_ext <= 1'h0;
        wr(`IOM_AUX2_OFS, 8'h01);
        tick(4);
        chk({7'h00, osc_output_pin_oe}, 8'h00);
        @(posedge clk);
        osc_src_rc_or_ext <= 1'h1;
        tick(4);
        last = osc_output_pin_o;
        n = 0;
        for (int k = 0; k < 16; k++)
        begin
            tick(1);
            n += int'(osc_output_pin_o !== last);
            last = osc_output_pin_o;
        end
        chk(n[7:0], 8'h08);
        chk({7'h00, osc_output_pin_oe}, 8'h01);
        wr(`IOM_AUX2_OFS, 8'h00);
        tick(4);
        chk({6'h00, osc_output_pin_oe, osc_output_pin_o}, 8'h00);
        // Pulse 0 arrives while disabled and must not toggle
        for (int k = 0; k < 4; k++)
        begin
            if (k == 1)
                wr(`IOM_AUX2_OFS, 8'h0c);
            @(posedge clk);
            timer0_ovf <= 1'h1;
            timer1_ovf <= k[0];
            @(posedge clk);
            timer0_ovf <= 1'h0;
            timer1_ovf <= 1'h0;
        end
        tick(2);
        chk({6'h00, timer0_toggle_out, timer1_toggle_out}, 8'h02);
        $display("test clock and timers done");
        // Leave pin 0 input-only so the reset has something to undo
        wr(`IOM_P0_MODE_A_OFS, 8'h01);
        @(posedge clk);
        {strap_reset_level_high_sel, strap_reset_pin_disable} <= 2'h2;
        ext_low[12] <= 1'h1;
        do_reset();
        tick(4);
        chk({6'h00, port_reset_level, ext_reset_req}, 8'h03);
        drv_chk(0, exp_drv(2'h0, 1'h1));
        @(posedge clk);
        {strap_reset_level_high_sel, strap_reset_pin_disable} <= 2'h1;
        ext_low[12] <= 1'h0;
        do_reset();
        tick(4);
        chk({5'h00, port_reset_level, ext_reset_req, pin_level[12]}, 8'h01);
        $display("test straps done");
        conclude();
    end
endmodule

// File: rtl/iom_pkg.sv
package iom_pkg;
    typedef enum logic [1:0] {
        IOM_QUASI,
        IOM_PUSH_PULL,
        IOM_INPUT_ONLY,
        IOM_OPEN_DRAIN
    } iom_mode_t;

    typedef struct packed {
        logic very_weak_pu;
        logic weak_pu;
        logic strong_pu;
        logic pull_down;
        logic schmitt;
    } iom_drv_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iom_bus_req_t;
endpackage

// File: rtl/iom_port_ctrl.sv
`include "iom_regs.svh"

module iom_port_ctrl
    import iom_pkg::*;
#(
    parameter int NPORTS = 5
)
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire iom_bus_req_t      bus_req,
    output logic [7:0]             bus_rdata,
    input  wire logic [NPORTS*8-1:0] port_latch,
    input  wire logic [NPORTS*8-1:0] pin_in,
    input  wire logic              strap_reset_level_high_sel,
    input  wire logic              strap_reset_pin_disable,
    input  wire logic              osc_src_rc_or_ext,
    input  wire logic              timer0_ovf,
    input  wire logic              timer1_ovf,
    output iom_drv_t [NPORTS*8-1:0] pin_drv,
    output logic [NPORTS*8-1:0]    pin_level,
    output logic                   port_reset_level,
    output logic                   ext_reset_req,
    output logic                   timer0_toggle_out,
    output logic                   timer1_toggle_out,
    output logic                   osc_output_pin_o,
    output logic                   osc_output_pin_oe
);
    localparam int NPINS = NPORTS * 8;

    // Address decode and pin indices are written for five ports
    if (NPORTS != 5)
    begin : g_bad_nports
        $error("iom_port_ctrl serves exactly five ports");
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] mode_a_r [NPORTS];
    logic [7:0] mode_b_r [NPORTS];
    logic [7:0] thresh_r;
    logic [7:0] aux2_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int p = 0; p < NPORTS; p++)
            begin
                mode_a_r[p] <= `IOM_REG_RST;
                mode_b_r[p] <= `IOM_REG_RST;
            end
        end
        else if (bus_req.wr)
        begin
            unique case (bus_req.addr)
                `IOM_P0_MODE_A_OFS: mode_a_r[0] <= bus_req.wdata;
                `IOM_P0_MODE_B_OFS: mode_b_r[0] <= bus_req.wdata;
                `IOM_P1_MODE_A_OFS: mode_a_r[1] <= bus_req.wdata & `IOM_P1_MASK;
                `IOM_P1_MODE_B_OFS: mode_b_r[1] <= bus_req.wdata & `IOM_P1_MASK;
                `IOM_P2_MODE_A_OFS: mode_a_r[2] <= bus_req.wdata;
                `IOM_P2_MODE_B_OFS: mode_b_r[2] <= bus_req.wdata;
                `IOM_P3_MODE_A_OFS: mode_a_r[3] <= bus_req.wdata;
                `IOM_P3_MODE_B_OFS: mode_b_r[3] <= bus_req.wdata;
                `IOM_P4_MODE_A_OFS: mode_a_r[4] <= bus_req.wdata & `IOM_P4_MASK;
                `IOM_P4_MODE_B_OFS: mode_b_r[4] <= bus_req.wdata & `IOM_P4_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            thresh_r <= `IOM_REG_RST;
        else if (bus_req.wr && bus_req.addr == `IOM_THRESH_OFS)
            thresh_r <= bus_req.wdata & `IOM_THRESH_MASK;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            aux2_r <= `IOM_REG_RST;
        else if (bus_req.wr && bus_req.addr == `IOM_AUX2_OFS)
            aux2_r <= bus_req.wdata & `IOM_AUX2_MASK;
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;

    always_comb
    begin
        unique case (bus_req.addr)
            `IOM_P0_MODE_A_OFS: rdata_nxt = mode_a_r[0];
            `IOM_P0_MODE_B_OFS: rdata_nxt = mode_b_r[0];
            `IOM_P1_MODE_A_OFS: rdata_nxt = mode_a_r[1];
            `IOM_P1_MODE_B_OFS: rdata_nxt = mode_b_r[1];
            `IOM_P2_MODE_A_OFS: rdata_nxt = mode_a_r[2];
            `IOM_P2_MODE_B_OFS: rdata_nxt = mode_b_r[2];
            `IOM_P3_MODE_A_OFS: rdata_nxt = mode_a_r[3];
            `IOM_P3_MODE_B_OFS: rdata_nxt = mode_b_r[3];
            `IOM_P4_MODE_A_OFS: rdata_nxt = mode_a_r[4];
            `IOM_P4_MODE_B_OFS: rdata_nxt = mode_b_r[4];
            `IOM_THRESH_OFS:    rdata_nxt = thresh_r;
            `IOM_AUX2_OFS:      rdata_nxt = aux2_r;
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // Data only in the cycle after the read strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            bus_rdata <= 8'h00;
        else if (bus_req.rd)
            bus_rdata <= rdata_nxt;
        else
            bus_rdata <= 8'h00;
    end

    // ------------------------------------------------------------
    // Boot straps, caught after reset release
    // ------------------------------------------------------------
    logic strap_done_r;
    logic rst_pin_dis_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_done_r     <= 1'b0;
            port_reset_level <= 1'b0;
            rst_pin_dis_r    <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            strap_done_r     <= 1'b1;
            port_reset_level <= strap_reset_level_high_sel;
            rst_pin_dis_r    <= strap_reset_pin_disable;
        end
    end

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    logic [NPINS-1:0] pin_meta_r;
    logic [NPINS-1:0] pin_sync_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else
        begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ext_reset_req <= 1'b0;
        else
            ext_reset_req <= strap_done_r && !rst_pin_dis_r
                             && !pin_sync_r[`IOM_DED_PIN_IDX];
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pin_level <= '0;
        else
        begin
            pin_level <= pin_sync_r;
            // Reset function hides the pin from the port input
            if (!rst_pin_dis_r)
                pin_level[`IOM_DED_PIN_IDX] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Strong pull-up pulse tracking
    // ------------------------------------------------------------
    logic [NPINS-1:0] latch_prev_r;
    logic [NPINS-1:0] latch_rise;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            latch_prev_r <= '0;
        else
            latch_prev_r <= port_latch;
    end

    assign latch_rise = port_latch & ~latch_prev_r;

    // ------------------------------------------------------------
    // Per-pin driver decode
    // ------------------------------------------------------------
    for (genvar i = 0; i < NPINS; i++)
    begin : g_pin
        localparam int P = i / 8;
        localparam int B = i % 8;
        iom_mode_t  mode;
        iom_drv_t   drv_nxt;
        logic       latch;
        logic [1:0] spu_cnt_r;

        always_comb
        begin
            mode = iom_mode_t'({mode_a_r[P][B], mode_b_r[P][B]});
            if (i == `IOM_DED_PIN_IDX)
                mode = IOM_INPUT_ONLY;
            else if (i == `IOM_SER_A_PIN_IDX || i == `IOM_SER_B_PIN_IDX)
                mode = IOM_OPEN_DRAIN;
        end

        assign latch = port_latch[i];

        // Counts the remaining strong pull-up clocks
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                spu_cnt_r <= 2'd0;
            else if (latch_rise[i] && mode == IOM_QUASI)
                spu_cnt_r <= 2'(`IOM_STRONG_PU_CLKS - 1);
            else if (spu_cnt_r != 2'd0)
                spu_cnt_r <= spu_cnt_r - 2'd1;
        end

        always_comb
        begin
            drv_nxt = '0;
            drv_nxt.schmitt = thresh_r[P];
            if (i == `IOM_DED_PIN_IDX)
                drv_nxt.schmitt = 1'b1;
            unique case (mode)
                IOM_QUASI:
                begin
                    drv_nxt.very_weak_pu = latch;
                    drv_nxt.weak_pu = latch && pin_sync_r[i];
                    drv_nxt.strong_pu = (latch_rise[i] || spu_cnt_r != 2'd0) && latch;
                    drv_nxt.pull_down = !latch;
                end
                IOM_PUSH_PULL:
                begin
                    drv_nxt.strong_pu = latch;
                    drv_nxt.pull_down = !latch;
                end
                IOM_INPUT_ONLY:
                begin
                    drv_nxt.strong_pu = 1'b0;
                end
                IOM_OPEN_DRAIN:
                begin
                    drv_nxt.pull_down = !latch;
                end
            endcase
        end

        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                pin_drv[i] <= '0;
            else
                pin_drv[i] <= drv_nxt;
        end
    end

    // ------------------------------------------------------------
    // Timer toggle outputs
    // ------------------------------------------------------------
    // toggle per overflow
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            timer0_toggle_out <= 1'b0;
        else if (aux2_r[`IOM_AUX2_T0TGL_BIT] && timer0_ovf)
            timer0_toggle_out <= !timer0_toggle_out;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            timer1_toggle_out <= 1'b0;
        else if (aux2_r[`IOM_AUX2_T1TGL_BIT] && timer1_ovf)
            timer1_toggle_out <= !timer1_toggle_out;
    end

    // ------------------------------------------------------------
    // Clock output, CPU clock divided by four
    // ------------------------------------------------------------
    localparam logic [1:0] DIV_HALF = 2'(`IOM_CLKOUT_DIV / 2 - 1);
    logic [1:0] div_cnt_r;
    logic       clkout_on;

    assign clkout_on = aux2_r[`IOM_AUX2_CLKOUT_BIT] && osc_src_rc_or_ext;

    // runs with the oscillator, Idle included
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_cnt_r        <= 2'd0;
            osc_output_pin_o <= 1'b0;
        end
        else if (!clkout_on)
        begin
            div_cnt_r        <= 2'd0;
            osc_output_pin_o <= 1'b0;
        end
        else if (div_cnt_r == DIV_HALF)
        begin
            div_cnt_r        <= 2'd0;
            osc_output_pin_o <= !osc_output_pin_o;
        end
        else
            div_cnt_r <= div_cnt_r + 2'd1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            osc_output_pin_oe <= 1'b0;
        else
            osc_output_pin_oe <= clkout_on;
    end
endmodule

// File: rtl/iom_regs.svh
`ifndef IOM_REGS_SVH
`define IOM_REGS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define IOM_P3_MODE_A_OFS  8'h9e
`define IOM_P3_MODE_B_OFS  8'h9f
`define IOM_P0_MODE_A_OFS  8'hb1
`define IOM_P0_MODE_B_OFS  8'hb2
`define IOM_P1_MODE_A_OFS  8'hb3
`define IOM_P1_MODE_B_OFS  8'hb4
`define IOM_P2_MODE_A_OFS  8'hb5
`define IOM_P2_MODE_B_OFS  8'hb6
`define IOM_THRESH_OFS     8'hec
`define IOM_AUX2_OFS       8'ha6
`define IOM_P4_MODE_A_OFS  8'hfa
`define IOM_P4_MODE_B_OFS  8'hfb
// ------------------------------------------------------------
// Reset values and implemented bits
// ------------------------------------------------------------
`define IOM_REG_RST        8'h00
`define IOM_P1_MASK        8'h8f
`define IOM_P4_MASK        8'h0f
`define IOM_THRESH_MASK    8'h1f
`define IOM_AUX2_MASK      8'h0d
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define IOM_AUX2_CLKOUT_BIT 0
`define IOM_AUX2_T0TGL_BIT  2
`define IOM_AUX2_T1TGL_BIT  3
`define IOM_DED_PIN_IDX     12
`define IOM_SER_A_PIN_IDX   13
`define IOM_SER_B_PIN_IDX   14
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define IOM_STRONG_PU_CLKS  2
`define IOM_CLKOUT_DIV      4
`endif
